/* src/retention_pkg.sv */
// Constants and carrier types for the retention mode controller.
// Assumes one 125 MHz clock and an AHB-Lite register bus.
package retention_pkg;

   localparam int           NUM_PADS      = 8;
   localparam int           CLK_PERIOD_NS = 8;

   // Entry and exit must finish within this time
   localparam int           SWITCH_MAX_NS = 1000;
   localparam int           SWITCH_MAX_CYC = SWITCH_MAX_NS / CLK_PERIOD_NS;

   // Register byte addresses
   localparam logic [7:0]   CTRL_ADDR     = 8'h00;
   localparam logic [7:0]   STATUS_ADDR   = 8'h04;
   localparam logic [7:0]   HOLD_EN_ADDR  = 8'h08;
   localparam logic [7:0]   PULL_EN_ADDR  = 8'h0C;
   localparam logic [7:0]   PULL_UP_ADDR  = 8'h10;

   // Control fields
   localparam int           CTRL_GATE_BIT = 0;
   localparam int           CTRL_HOLD_BIT = 1;

   // Status fields
   localparam int           STAT_ACT_BIT  = 0;
   localparam int           STAT_REQ_BIT  = 1;
   localparam int           STAT_PRM_BIT  = 2;

   // Reset values
   localparam logic [1:0]   CTRL_RST      = 2'h0;
   localparam logic [NUM_PADS-1:0] PAD_CFG_RST = '0;

   localparam logic [1:0]   HTRANS_NONSEQ = 2'h2;

   typedef enum logic [0:0]
   {
      MODE_NORMAL = 1'b0,
      MODE_RETAIN = 1'b1
   } mode_type;

   // What the block drives onto the pads
   typedef struct packed
   {
      logic [NUM_PADS-1:0] out;
      logic [NUM_PADS-1:0] oe;
      logic [NUM_PADS-1:0] pull_en;
      logic [NUM_PADS-1:0] pull_up;
   } pad_drive_type;

endpackage

/* src/retention_ctrl.sv */
// Retention mode entry and exit with per-pad state control.
// Request pin and pad inputs are asynchronous; permit and core
// data come from logic on core_clk_i. Registers over AHB-Lite.
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps

module retention_ctrl
(
   input  wire logic                        core_clk_i,
   input  wire logic                        sys_rst_i,
   input  wire logic                        retention_request_pin_n_i,
   input  wire logic                        retention_permit_i,
   input  wire logic [retention_pkg::NUM_PADS-1:0] pad_in_i,
   input  wire logic [retention_pkg::NUM_PADS-1:0] core_out_i,
   input  wire logic [retention_pkg::NUM_PADS-1:0] core_dir_i,
   output logic [retention_pkg::NUM_PADS-1:0]      core_in_o,
   output retention_pkg::pad_drive_type            pad_o,
   output logic                                    retention_active_o,
   input  wire logic                        hsel_i,
   input  wire logic [31:0]                 haddr_i,
   input  wire logic [1:0]                  htrans_i,
   input  wire logic                        hwrite_i,
   input  wire logic [2:0]                  hsize_i,
   input  wire logic [31:0]                 hwdata_i,
   input  wire logic                        hready_i,
   output logic [31:0]                      hrdata_o,
   output logic                             hreadyout_o,
   output logic                             hresp_o
);

   localparam int N = retention_pkg::NUM_PADS;

   // Synchronisers for pins
   logic          req_meta_q, req_n_q;
   logic [N-1:0]  pad_meta_q, pad_sync_q;

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         req_meta_q <= 1'b1;
         req_n_q    <= 1'b1;
         pad_meta_q <= '0;
         pad_sync_q <= '0;
      end
      else
      begin
         req_meta_q <= retention_request_pin_n_i;
         req_n_q    <= req_meta_q;
         pad_meta_q <= pad_in_i;
         pad_sync_q <= pad_meta_q;
      end
   end

   // Register file state
   logic [1:0]    ctrl_q, ctrl_d;
   logic [N-1:0]  hold_en_q, hold_en_d;
   logic [N-1:0]  pull_en_q, pull_en_d;
   logic [N-1:0]  pull_up_q, pull_up_d;
   logic [31:0]   rdata_q, rdata_d;
   logic          wr_pend_q, wr_pend_d;
   logic [7:0]    wr_addr_q, wr_addr_d;

   // Retention state
   retention_pkg::mode_type mode_q, mode_d;
   logic [N-1:0]  held_in_q, held_in_d;
   logic [N-1:0]  held_out_q, held_out_d;
   retention_pkg::pad_drive_type pad_q, pad_d;
   logic [N-1:0]  core_in_q, core_in_d;

   logic          req_on, gated, hold_cap, enter_ok, active;
   logic          addr_ok;

   assign req_on   = ~req_n_q;
   assign gated    = ctrl_q[retention_pkg::CTRL_GATE_BIT];
   assign hold_cap = ctrl_q[retention_pkg::CTRL_HOLD_BIT];
   // Permit only matters when gating is on
   assign enter_ok = req_on & (~gated | retention_permit_i);
   assign active   = (mode_q == retention_pkg::MODE_RETAIN);
   assign addr_ok  = hsel_i & hready_i & htrans_i[1];

   // Bus and register next state
   always_comb
   begin
      ctrl_d    = ctrl_q;
      hold_en_d = hold_en_q;
      pull_en_d = pull_en_q;
      pull_up_d = pull_up_q;
      rdata_d   = 32'h0000_0000;
      wr_pend_d = addr_ok & hwrite_i;
      wr_addr_d = haddr_i[7:0];
      if (wr_pend_q)
      begin
         unique case (wr_addr_q)
            retention_pkg::CTRL_ADDR:    ctrl_d    = hwdata_i[1:0];
            retention_pkg::HOLD_EN_ADDR: hold_en_d = hwdata_i[N-1:0];
            retention_pkg::PULL_EN_ADDR: pull_en_d = hwdata_i[N-1:0];
            retention_pkg::PULL_UP_ADDR: pull_up_d = hwdata_i[N-1:0];
            default:                     ctrl_d    = ctrl_q;
         endcase
      end
      if (addr_ok & ~hwrite_i)
      begin
         unique case (haddr_i[7:0])
            retention_pkg::CTRL_ADDR:    rdata_d[1:0]   = ctrl_q;
            retention_pkg::STATUS_ADDR:
            begin
               rdata_d[retention_pkg::STAT_ACT_BIT] = active;
               rdata_d[retention_pkg::STAT_REQ_BIT] = req_on;
               rdata_d[retention_pkg::STAT_PRM_BIT] = retention_permit_i;
            end
            retention_pkg::HOLD_EN_ADDR: rdata_d[N-1:0] = hold_en_q;
            retention_pkg::PULL_EN_ADDR: rdata_d[N-1:0] = pull_en_q;
            retention_pkg::PULL_UP_ADDR: rdata_d[N-1:0] = pull_up_q;
            default:                     rdata_d        = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         ctrl_q    <= retention_pkg::CTRL_RST;
         hold_en_q <= retention_pkg::PAD_CFG_RST;
         pull_en_q <= retention_pkg::PAD_CFG_RST;
         pull_up_q <= retention_pkg::PAD_CFG_RST;
         rdata_q   <= 32'h0000_0000;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end
      else
      begin
         ctrl_q    <= ctrl_d;
         hold_en_q <= hold_en_d;
         pull_en_q <= pull_en_d;
         pull_up_q <= pull_up_d;
         rdata_q   <= rdata_d;
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
      end
   end

   assign hrdata_o    = rdata_q;
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;

   // Mode and per-pad next state
   always_comb
   begin
      mode_d     = mode_q;
      held_in_d  = held_in_q;
      held_out_d = held_out_q;
      unique case (mode_q)
         retention_pkg::MODE_NORMAL:
         begin
            if (enter_ok)
            begin
               mode_d     = retention_pkg::MODE_RETAIN;
               held_in_d  = pad_sync_q;
               held_out_d = pad_q.out;
            end
         end
         retention_pkg::MODE_RETAIN:
         begin
            if (!req_on)
            begin
               mode_d = retention_pkg::MODE_NORMAL;
            end
         end
      endcase
   end

   logic [N-1:0] hold_on;
   assign hold_on = hold_en_q & {N{hold_cap}};

   generate
      for (genvar i = 0; i < N; i++)
      begin : g_pad
         always_comb
         begin
            pad_d.out[i]     = core_out_i[i];
            pad_d.oe[i]      = core_dir_i[i];
            pad_d.pull_en[i] = pull_en_q[i];
            pad_d.pull_up[i] = pull_up_q[i];
            core_in_d[i]     = pad_sync_q[i];
            if (mode_d == retention_pkg::MODE_RETAIN)
            begin
               pad_d.out[i] = 1'b0;
               pad_d.oe[i]  = 1'b0;
               if (hold_on[i] & core_dir_i[i] & ~pull_en_q[i])
               begin
                  pad_d.pull_en[i] = 1'b1;
                  pad_d.pull_up[i] = held_out_d[i];
               end
               // Held inputs, direction 0 or 1, read captured value
               core_in_d[i] = hold_on[i] ? held_in_d[i] : 1'b1;
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         mode_q     <= retention_pkg::MODE_NORMAL;
         held_in_q  <= '0;
         held_out_q <= '0;
         pad_q      <= '0;
         core_in_q  <= '0;
      end
      else
      begin
         mode_q     <= mode_d;
         held_in_q  <= held_in_d;
         held_out_q <= held_out_d;
         pad_q      <= pad_d;
         core_in_q  <= core_in_d;
      end
   end

   assign pad_o              = pad_q;
   assign core_in_o          = core_in_q;
   assign retention_active_o = active;

   // Checks
   sequence s_gate_blocked;
      !active && gated && !retention_permit_i;
   endsequence

   sequence s_entry_req;
      !active && req_on && (!gated || retention_permit_i);
   endsequence

   a_gated_entry_block: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      s_gate_blocked |=> !active)
      else $error("Entered retention without permit");

   a_entry_bound: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      s_entry_req |-> ##1 active)
      else $error("Retention entry late");

   a_pin_only_follow: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      !gated && !req_on |=> !active)
      else $error("Pin-only mode did not follow request");

   a_exit_ignores_permit: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      active && !req_on |=> !active)
      else $error("Retention exit late");

   a_core_in_high: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      active && $past(active) && !$past(hold_cap) |-> core_in_o == '1)
      else $error("Core input not forced high");

   a_held_stable: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      active && $past(active) |-> $stable(held_in_q))
      else $error("Held input changed in retention");

   a_pad_tristate: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      active && $past(active) |-> pad_o.oe == '0)
      else $error("Pad driven during retention");

   a_pull_kept: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      active && $past(active) && !$past(hold_cap)
         |-> pad_o.pull_en == $past(pull_en_q))
      else $error("Configured pull not kept");

   a_held_core_in: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      active && $past(active) |-> (core_in_o & $past(hold_on))
         == (held_in_q & $past(hold_on)))
      else $error("Held input not presented to core");

endmodule

/* verif/retention_partner.sv */
// Model of the external controller pin and the user logic permit.
// Assumes bench commands arrive on the core clock.
`timescale 1ns/1ps

module retention_partner
(
   input  wire logic core_clk_i,
   input  wire logic sys_rst_i,
   input  wire logic request_i,
   input  wire logic permit_i,
   input  wire logic active_i,
   output logic      request_pin_n_o,
   output logic      permit_o
);
   logic drop_q;
   logic drop_d;
   logic active_q;

   // Permit withdrawn after each exit until user logic rearms
   always_comb
   begin
      drop_d = drop_q;
      if (active_q && !active_i)
         drop_d = 1'b1;
      else if (!permit_i)
         drop_d = 1'b0;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         drop_q          <= 1'b0;
         active_q        <= 1'b0;
         request_pin_n_o <= 1'b1;
         permit_o        <= 1'b0;
      end
      else
      begin
         drop_q          <= drop_d;
         active_q        <= active_i;
         request_pin_n_o <= ~request_i;
         permit_o        <= permit_i && !drop_d;
      end
   end
endmodule

/* verif/retention_ctrl_tb.sv */
// Self-checking bench for the retention mode controller.
// Assumes the partner model drives request pin and permit.
`timescale 1ns/1ps

module retention_ctrl_tb;
   localparam int MAXC = retention_pkg::SWITCH_MAX_CYC;
   logic                         core_clk = 1'b0;
   logic                         sys_rst = 1'b1;
   logic                         req = 1'b0;
   logic                         prm = 1'b0;
   logic                         pin_n;
   logic                         permit;
   logic [7:0]                   pad_in = 8'h00;
   logic [7:0]                   core_out = 8'h00;
   logic [7:0]                   core_dir = 8'h00;
   logic [7:0]                   core_in;
   retention_pkg::pad_drive_type pad;
   logic                         active;
   logic                         hsel = 1'b0;
   logic [31:0]                  haddr = 32'h0000_0000;
   logic [1:0]                   htrans = 2'h0;
   logic                         hwrite = 1'b0;
   logic [31:0]                  hwdata = 32'h0000_0000;
   logic [31:0]                  hrdata;
   logic                         hready;
   logic                         hresp;
   logic [31:0]                  rd;
   int                           n_mismatch = 0;
   int                           cmp_count = 0;

   always #4 core_clk = ~core_clk;

   retention_partner partner
   (
      .core_clk_i(core_clk), .sys_rst_i(sys_rst), .request_i(req),
      .permit_i(prm), .active_i(active), .request_pin_n_o(pin_n),
      .permit_o(permit)
   );

   retention_ctrl dut
   (
      .core_clk_i(core_clk), .sys_rst_i(sys_rst),
      .retention_request_pin_n_i(pin_n), .retention_permit_i(permit),
      .pad_in_i(pad_in), .core_out_i(core_out), .core_dir_i(core_dir),
      .core_in_o(core_in), .pad_o(pad), .retention_active_o(active),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
      .hresp_o(hresp)
   );

   task automatic end_sim;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic bus_wait;
      int n;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1)
      begin
         n_mismatch++;
         end_sim;
      end
   endtask

   // One single word transfer; read data lands in rd
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= retention_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      bus_wait;
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      bus_wait;
      rd = hrdata;
      chk("hresp", {31'h0, hresp}, 32'h0000_0000);
   endtask

   task automatic wait_act(input logic exp);
      int n;
      n = 0;
      while (active !== exp && n < MAXC)
      begin
         @(posedge core_clk);
         n++;
      end
      chk("active", {31'h0, active}, {31'h0, exp});
      if (active !== exp)
         end_sim;
   endtask

   // Any entry seen in the window counts, not only the last cycle
   task automatic no_entry;
      logic seen;
      seen = 1'b0;
      repeat (MAXC)
      begin
         @(posedge core_clk);
         seen = seen | active;
      end
      chk("idle", {31'h0, seen}, 32'h0000_0000);
   endtask

   initial
   begin
      repeat (50000) @(posedge core_clk);
      n_mismatch++;
      end_sim;
   end

   initial
   begin
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      for (int i = 0; i < 6; i++)
      begin
         bus(1'b0, 8'(i * 4), 32'h0000_0000);
         chk("reset_reg", rd, 32'h0000_0000);
      end
      bus(1'b1, 8'h14, 32'hFFFF_FFFF);
      bus(1'b0, 8'h14, 32'h0000_0000);
      chk("unmapped", rd, 32'h0000_0000);
      bus(1'b1, retention_pkg::HOLD_EN_ADDR, 32'h0000_000F);
      bus(1'b1, retention_pkg::PULL_EN_ADDR, 32'h0000_0033);
      bus(1'b1, retention_pkg::PULL_UP_ADDR, 32'h0000_0011);
      bus(1'b0, retention_pkg::HOLD_EN_ADDR, 32'h0000_0000);
      chk("hold_en", rd, 32'h0000_000F);
      core_dir <= 8'h5A;
      core_out <= 8'hCE;
      pad_in   <= 8'hA5;
      // Pin-only, hold not available
      prm <= 1'b1;
      no_entry;
      chk("out_norm", {24'h0, pad.out}, 32'h0000_00CE);
      chk("oe_norm", {24'h0, pad.oe}, 32'h0000_005A);
      chk("in_norm", {24'h0, core_in}, 32'h0000_00A5);
      prm <= 1'b0;
      req <= 1'b1;
      wait_act(1'b1);
      chk("core_in", {24'h0, core_in}, 32'h0000_00FF);
      chk("oe", {24'h0, pad.oe}, 32'h0000_0000);
      chk("out", {24'h0, pad.out}, 32'h0000_0000);
      chk("pull_en", {24'h0, pad.pull_en}, 32'h0000_0033);
      chk("pull_up", {24'h0, pad.pull_up & 8'h33}, 32'h0000_0011);
      req <= 1'b0;
      wait_act(1'b0);
      // Permit-gated entry
      bus(1'b1, retention_pkg::CTRL_ADDR, 32'h0000_0001);
      req <= 1'b1;
      no_entry;
      req <= 1'b0;
      // Let the synced request drop before permit rises
      repeat (4) @(posedge core_clk);
      prm <= 1'b1;
      no_entry;
      req <= 1'b1;
      wait_act(1'b1);
      bus(1'b0, retention_pkg::STATUS_ADDR, 32'h0000_0000);
      chk("status", rd, 32'h0000_0007);
      req <= 1'b0;
      wait_act(1'b0);
      req <= 1'b1;
      no_entry;
      req <= 1'b0;
      prm <= 1'b0;
      repeat (4) @(posedge core_clk);
      // Hold-capable, pin-only
      bus(1'b1, retention_pkg::CTRL_ADDR, 32'h0000_0002);
      req <= 1'b1;
      wait_act(1'b1);
      chk("core_in", {24'h0, core_in}, 32'h0000_00F5);
      chk("oe", {24'h0, pad.oe}, 32'h0000_0000);
      chk("pull_en", {24'h0, pad.pull_en}, 32'h0000_003B);
      chk("pull_up", {24'h0, pad.pull_up & 8'h3B}, 32'h0000_0019);
      pad_in <= 8'h5A;
      repeat (10) @(posedge core_clk);
      chk("held", {24'h0, core_in}, 32'h0000_00F5);
      req <= 1'b0;
      wait_act(1'b0);
      end_sim;
   end
endmodule
